/* cfg_menu_asserts.sv */
// port checker of the menu controller
// assumes binding to the top module by port name
`timescale 1ns/1ps
module cfg_menu_asserts (
   input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready,
   input wire logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid,
   input wire logic        s_axi_bready, s_axi_arvalid, s_axi_arready,
   input wire logic        s_axi_rvalid, s_axi_rready, disp_flash,
   input wire logic        transport_state,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  disp_loop
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid) else $error("write response dropped early");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
   a_write_busy: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
   a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   a_transport_return: assert property ($rose(transport_state)
      |-> $rose(s_axi_bvalid)) else $error("transport restored without reset");
   a_flash_in_menu: assert property (disp_flash
      |-> disp_loop == cfg_menu_pkg::LOOP_SETUP) else $error("flash outside menu");
   c_left_transport: cover property ($fell(transport_state));
   c_editing: cover property ($rose(disp_flash));
   c_write_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule

/* cfg_menu_pkg.sv */
// constants, register map and state encoding of the configuration menu
// assumes a 25 MHz aclk; long key and idle times are overridable at top
package cfg_menu_pkg;

   // clock and documented times
   localparam longint CLK_HZ       = 25_000_000;
   localparam longint KEY_HOLD_MS  = 5000;
   localparam longint SAVE_HOLD_MS = 2000;
   localparam longint IDLE_S       = 240;
   // least times, so the cycle counts round up
   localparam logic [35:0] HOLD_CYC =
      36'((KEY_HOLD_MS * CLK_HZ + 999) / 1000);
   localparam logic [35:0] SAVE_CYC =
      36'((SAVE_HOLD_MS * CLK_HZ + 999) / 1000);
   localparam logic [35:0] IDLE_CYC = 36'(IDLE_S * CLK_HZ);

   // configuration session limit
   localparam logic [5:0] MAX_SESSIONS = 6'h32;

   // menu layout
   localparam logic [4:0] LAST_ITEM     = 5'h17;
   localparam logic [4:0] ITEM_DATE     = 5'h02;
   localparam logic [4:0] ITEM_TIME     = 5'h03;
   localparam logic [4:0] ITEM_HC_SHIFT = 5'h0C;
   localparam logic [4:0] ITEM_T_OFFSET = 5'h0D;
   localparam logic [4:0] ITEM_LOCK     = 5'h17;
   localparam logic [1:0] LOOP_USER     = 2'h0;
   localparam logic [1:0] LOOP_SETUP    = 2'h3;
   localparam logic [2:0] TYPE_HEAT_COOL = 3'h6;
   localparam logic [2:0] LEFT_DIGIT    = 3'h7;
   localparam logic [3:0] DIGIT_MAX     = 4'h9;

   // register offsets (byte addresses)
   localparam logic [7:0] OFS_CONTROL    = 8'h00;
   localparam logic [7:0] OFS_CONFIG     = 8'h04;
   localparam logic [7:0] OFS_DISABLE    = 8'h08;
   localparam logic [7:0] OFS_NOMINAL    = 8'h0C;
   localparam logic [7:0] OFS_STATUS     = 8'h10;
   localparam logic [7:0] OFS_DISPLAY    = 8'h14;
   localparam logic [7:0] OFS_PARAM_SEL  = 8'h18;
   localparam logic [7:0] OFS_PARAM_DATA = 8'h1C;

   // field positions and reset values
   localparam int CTRL_TOTAL_RESET = 0;
   localparam int CFG_TYPE_LSB     = 0;
   localparam int CFG_T_OFS_EXCL   = 4;
   localparam int STAT_TRANSPORT   = 0;
   localparam int STAT_ACCESS      = 1;
   localparam int STAT_LIMIT       = 2;
   localparam int STAT_IN_MENU     = 3;
   localparam int STAT_EDITING     = 4;
   localparam int STAT_COUNT_LSB   = 8;
   localparam logic [2:0]  RST_METER_TYPE = 3'h1;
   localparam logic [23:0] RST_DISABLE    = 24'h000000;
   localparam logic [15:0] RST_NOMINAL    = 16'h0000;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   typedef enum logic [2:0] {
      ST_USER     = 3'b000,
      ST_LOOP_SEL = 3'b001,
      ST_MENU     = 3'b010,
      ST_EDIT     = 3'b011,
      ST_SAVE_OK  = 3'b100,
      ST_LOCK_OK  = 3'b101
   } menu_st_t;

endpackage

/* config_menu_access_control.sv */
// front-key configuration menu with access control and AXI4-Lite registers
// assumes debounced keys synchronous to aclk
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Operation
// - at most fifty sessions, counted persistently
// - limit reached refuses menu until total reset
// - transport state opens menu without housing separation
// - leave transport on flow one percent or lock
// - only total reset restores transport state
// - in operation, separation and reassembly grant access
// - primary held plus arrow leaves the menu
// - four idle minutes return to user loop
// - lock item hold animates, shows OK, blocks
// - in operation any exit blocks renewed access
// - in transport only the lock item blocks
// - five second hold opens loop selection
// - no secondary readings, four digit item index
// - arrows step items, primary opens item
// - leftmost digit flashes, presses change, arrows move
// - primary hold stores value and shows OK
// - disabled items show Off, press lights frames
// - heat cool shift editable only on type six
// - modules and service tool may set time/date
// - sensor offset disabled by country code
module config_menu_access_control #(
   parameter logic [35:0] HOLD_CYC = cfg_menu_pkg::HOLD_CYC,
   parameter logic [35:0] SAVE_CYC = cfg_menu_pkg::SAVE_CYC,
   parameter logic [35:0] IDLE_CYC = cfg_menu_pkg::IDLE_CYC
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address and data
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // front keys and housing switch
   input  wire logic        key_primary,
   input  wire logic        key_left,
   input  wire logic        key_right,
   input  wire logic        housing_open,
   // measured flow, same unit as nominal_flow_rate
   input  wire logic [15:0] flow_rate,
   // time/date writes from plug-in modules
   input  wire logic        ext_we,
   input  wire logic [4:0]  ext_item,
   input  wire logic [31:0] ext_data,
   // display drive
   output logic [1:0]       disp_loop,
   output logic [4:0]       disp_index,
   output logic [31:0]      disp_value,
   output logic [2:0]       disp_digit,
   output logic             disp_flash,
   output logic             disp_ok,
   output logic             disp_off,
   output logic             disp_frames,
   output logic [2:0]       disp_frame_level,
   // access state
   output logic             transport_state,
   output logic             menu_access
);

   typedef struct packed {
      cfg_menu_pkg::menu_st_t st;
      logic                   transport;
      logic                   armed;
      logic                   seen_open;
      logic [5:0]             count;
      logic                   saved;
      logic [1:0]             sel_loop;
      logic [4:0]             item;
      logic [2:0]             digit;
      logic [31:0]            edit_val;
      logic                   frames_lit;
      logic [35:0]            hold_cnt;
      logic                   held;
      logic [35:0]            idle_cnt;
      logic                   pk_d;
      logic                   kl_d;
      logic                   kr_d;
      logic [2:0]             meter_type;
      logic                   t_ofs_excl;
      logic [23:0]            disable_mask;
      logic [15:0]            nominal_flow_rate;
      logic [4:0]             param_sel;
      logic [23:0][31:0]      vals;
      logic                   aw_got;
      logic [7:0]             aw_addr;
      logic                   w_got;
      logic [31:0]            w_data;
      logic [3:0]             w_strb;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   rvalid;
      logic [31:0]            rdata;
      logic [1:0]             rresp;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   logic        pk_rise;
   logic        pk_fall;
   logic        kl_rise;
   logic        kr_rise;
   logic        short_press;
   logic        hold_hit;
   logic        save_hit;
   logic        limit_hit;
   logic        access;
   logic        item_off;
   logic        do_exit;
   logic        do_lock;
   logic [3:0]  cur_digit;
   logic [31:0] flow_pct;
   logic [31:0] wr_merged;
   logic [31:0] rd_word;
   logic        rd_ok;
   logic        wr_ok;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      return r;
   endfunction

   always_comb begin
      s_nxt = s_r;
      // key edges; hold timer saturates at the long hold
      pk_rise = key_primary & ~s_r.pk_d;
      pk_fall = ~key_primary & s_r.pk_d;
      kl_rise = key_left & ~s_r.kl_d;
      kr_rise = key_right & ~s_r.kr_d;
      short_press = pk_fall & ~s_r.held;
      hold_hit = key_primary && (s_r.hold_cnt == HOLD_CYC - 36'h1);
      save_hit = key_primary && (s_r.hold_cnt == SAVE_CYC - 36'h1);
      s_nxt.pk_d = key_primary;
      s_nxt.kl_d = key_left;
      s_nxt.kr_d = key_right;
      if (!key_primary) begin
         s_nxt.hold_cnt = 36'h0;
         s_nxt.held = 1'b0;
      end else if (s_r.hold_cnt != HOLD_CYC) begin
         s_nxt.hold_cnt = s_r.hold_cnt + 36'h1;
      end

      limit_hit = (s_r.count >= cfg_menu_pkg::MAX_SESSIONS);
      access = ~limit_hit & (s_r.transport | s_r.armed);
      item_off = s_r.disable_mask[s_r.item];
      if (s_r.item == cfg_menu_pkg::ITEM_HC_SHIFT &&
          s_r.meter_type != cfg_menu_pkg::TYPE_HEAT_COOL) begin
         item_off = 1'b1;
      end
      if (s_r.item == cfg_menu_pkg::ITEM_T_OFFSET && s_r.t_ofs_excl) begin
         item_off = 1'b1;
      end
      cur_digit = s_r.edit_val[s_r.digit*4 +: 4];
      do_exit = 1'b0;
      do_lock = 1'b0;

      // idle timer only runs inside the menu
      if (s_r.st == cfg_menu_pkg::ST_MENU || s_r.st == cfg_menu_pkg::ST_EDIT ||
          s_r.st == cfg_menu_pkg::ST_SAVE_OK) begin
         if (pk_rise | pk_fall | kl_rise | kr_rise) begin
            s_nxt.idle_cnt = 36'h0;
         end else begin
            s_nxt.idle_cnt = s_r.idle_cnt + 36'h1;
         end
      end else begin
         s_nxt.idle_cnt = 36'h0;
      end

      case (s_r.st)
         cfg_menu_pkg::ST_USER: begin
            if (hold_hit) begin
               s_nxt.st = cfg_menu_pkg::ST_LOOP_SEL;
               s_nxt.sel_loop = cfg_menu_pkg::LOOP_USER;
               s_nxt.held = 1'b1;
            end
         end
         cfg_menu_pkg::ST_LOOP_SEL: begin
            if (kr_rise) begin
               s_nxt.sel_loop = s_r.sel_loop + 2'h1;
            end else if (kl_rise) begin
               s_nxt.sel_loop = s_r.sel_loop - 2'h1;
            end else if (short_press) begin
               if (s_r.sel_loop == cfg_menu_pkg::LOOP_SETUP && access) begin
                  s_nxt.st = cfg_menu_pkg::ST_MENU;
                  s_nxt.item = 5'h00;
                  s_nxt.saved = 1'b0;
                  s_nxt.frames_lit = 1'b0;
               end else if (s_r.sel_loop != cfg_menu_pkg::LOOP_SETUP) begin
                  s_nxt.st = cfg_menu_pkg::ST_USER;
               end
            end
         end
         cfg_menu_pkg::ST_MENU: begin
            if (key_primary && (kl_rise || kr_rise)) begin
               do_exit = 1'b1;
               s_nxt.st = cfg_menu_pkg::ST_LOOP_SEL;
               s_nxt.held = 1'b1;
            end else if (kr_rise) begin
               s_nxt.item = (s_r.item == cfg_menu_pkg::LAST_ITEM) ?
                            5'h00 : s_r.item + 5'h01;
               s_nxt.frames_lit = 1'b0;
            end else if (kl_rise) begin
               s_nxt.item = (s_r.item == 5'h00) ?
                            cfg_menu_pkg::LAST_ITEM : s_r.item - 5'h01;
               s_nxt.frames_lit = 1'b0;
            end else if (hold_hit && s_r.item == cfg_menu_pkg::ITEM_LOCK) begin
               do_lock = 1'b1;
               s_nxt.st = cfg_menu_pkg::ST_LOCK_OK;
               s_nxt.held = 1'b1;
            end else if (short_press && s_r.item != cfg_menu_pkg::ITEM_LOCK) begin
               if (item_off) begin
                  s_nxt.frames_lit = 1'b1;
               end else begin
                  s_nxt.st = cfg_menu_pkg::ST_EDIT;
                  s_nxt.digit = cfg_menu_pkg::LEFT_DIGIT;
                  s_nxt.edit_val = s_r.vals[s_r.item];
               end
            end
         end
         cfg_menu_pkg::ST_EDIT: begin
            if (save_hit) begin
               s_nxt.vals[s_r.item] = s_r.edit_val;
               s_nxt.saved = 1'b1;
               s_nxt.st = cfg_menu_pkg::ST_SAVE_OK;
               s_nxt.held = 1'b1;
            end else if (short_press) begin
               s_nxt.edit_val[s_r.digit*4 +: 4] =
                  (cur_digit >= cfg_menu_pkg::DIGIT_MAX) ?
                  4'h0 : cur_digit + 4'h1;
            end else if (kr_rise && s_r.digit != 3'h0) begin
               s_nxt.digit = s_r.digit - 3'h1;
            end else if (kl_rise && s_r.digit != cfg_menu_pkg::LEFT_DIGIT) begin
               s_nxt.digit = s_r.digit + 3'h1;
            end
         end
         cfg_menu_pkg::ST_SAVE_OK: begin
            // OK until release, then stored value
            if (pk_fall) begin
               s_nxt.st = cfg_menu_pkg::ST_MENU;
            end
         end
         cfg_menu_pkg::ST_LOCK_OK: begin
            if (pk_fall) begin
               s_nxt.st = cfg_menu_pkg::ST_USER;
            end
         end
         default: begin
            s_nxt.st = cfg_menu_pkg::ST_USER;
         end
      endcase

      if ((s_r.st == cfg_menu_pkg::ST_MENU || s_r.st == cfg_menu_pkg::ST_EDIT ||
           s_r.st == cfg_menu_pkg::ST_SAVE_OK) &&
          s_r.idle_cnt == IDLE_CYC - 36'h1 && !do_exit && !do_lock) begin
         do_exit = 1'b1;
         s_nxt.st = cfg_menu_pkg::ST_USER;
      end

      if (do_exit || do_lock) begin
         if (!s_r.transport || do_lock) begin
            s_nxt.armed = 1'b0;
         end
         if (s_r.saved && !limit_hit) begin
            s_nxt.count = s_r.count + 6'h01;
         end
      end
      if (do_lock) begin
         s_nxt.transport = 1'b0;
      end

      // leaving transport state is one-way; only total reset returns
      flow_pct = {16'h0000, flow_rate} * 32'h64;
      if (s_r.nominal_flow_rate != 16'h0000 &&
          flow_pct >= {16'h0000, s_r.nominal_flow_rate}) begin
         s_nxt.transport = 1'b0;
      end

      // reassembly after separation re-arms access
      if (housing_open) begin
         s_nxt.seen_open = 1'b1;
      end else if (s_r.seen_open) begin
         s_nxt.seen_open = 1'b0;
         s_nxt.armed = 1'b1;
      end

      if (ext_we && (ext_item == cfg_menu_pkg::ITEM_DATE ||
                     ext_item == cfg_menu_pkg::ITEM_TIME)) begin
         s_nxt.vals[ext_item] = ext_data;
      end

      // axi4-lite write: address and data taken in either order
      if (s_axi_awvalid && !s_r.aw_got && !s_r.bvalid) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_r.w_got && !s_r.bvalid) begin
         s_nxt.w_got = 1'b1;
         s_nxt.w_data = s_axi_wdata;
         s_nxt.w_strb = s_axi_wstrb;
      end
      wr_ok = 1'b1;
      wr_merged = 32'h00000000;
      if (s_r.aw_got && s_r.w_got) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         case (s_r.aw_addr)
            cfg_menu_pkg::OFS_CONTROL: begin
               if (s_r.w_strb[0] && s_r.w_data[cfg_menu_pkg::CTRL_TOTAL_RESET])
               begin
                  s_nxt.transport = 1'b1;
                  s_nxt.count = 6'h00;
                  s_nxt.armed = 1'b0;
                  s_nxt.st = cfg_menu_pkg::ST_USER;
               end
            end
            cfg_menu_pkg::OFS_CONFIG: begin
               wr_merged = merge({27'h0, s_r.t_ofs_excl, 1'b0, s_r.meter_type},
                                 s_r.w_data, s_r.w_strb);
               s_nxt.meter_type = wr_merged[cfg_menu_pkg::CFG_TYPE_LSB +: 3];
               s_nxt.t_ofs_excl = wr_merged[cfg_menu_pkg::CFG_T_OFS_EXCL];
            end
            cfg_menu_pkg::OFS_DISABLE: begin
               wr_merged = merge({8'h00, s_r.disable_mask}, s_r.w_data,
                                 s_r.w_strb);
               s_nxt.disable_mask = wr_merged[23:0];
            end
            cfg_menu_pkg::OFS_NOMINAL: begin
               wr_merged = merge({16'h0000, s_r.nominal_flow_rate}, s_r.w_data,
                                 s_r.w_strb);
               s_nxt.nominal_flow_rate = wr_merged[15:0];
            end
            cfg_menu_pkg::OFS_PARAM_SEL: begin
               if (s_r.w_strb[0]) begin
                  s_nxt.param_sel = s_r.w_data[4:0];
               end
            end
            cfg_menu_pkg::OFS_PARAM_DATA: begin
               if (s_r.param_sel <= cfg_menu_pkg::LAST_ITEM) begin
                  s_nxt.vals[s_r.param_sel] = merge(s_r.vals[s_r.param_sel],
                                                   s_r.w_data, s_r.w_strb);
               end else begin
                  wr_ok = 1'b0;
               end
            end
            cfg_menu_pkg::OFS_STATUS, cfg_menu_pkg::OFS_DISPLAY: begin
               wr_ok = 1'b1;
            end
            default: begin
               wr_ok = 1'b0;
            end
         endcase
         s_nxt.bresp = wr_ok ? cfg_menu_pkg::RESP_OKAY :
                               cfg_menu_pkg::RESP_SLVERR;
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end

      // axi4-lite read, one cycle after the address is taken
      rd_ok = 1'b1;
      rd_word = 32'h00000000;
      case (s_axi_araddr)
         cfg_menu_pkg::OFS_CONTROL: rd_word = 32'h00000000;
         cfg_menu_pkg::OFS_CONFIG:
            rd_word = {27'h0, s_r.t_ofs_excl, 1'b0, s_r.meter_type};
         cfg_menu_pkg::OFS_DISABLE: rd_word = {8'h00, s_r.disable_mask};
         cfg_menu_pkg::OFS_NOMINAL: rd_word = {16'h0000, s_r.nominal_flow_rate};
         cfg_menu_pkg::OFS_STATUS: begin
            rd_word[cfg_menu_pkg::STAT_TRANSPORT] = s_r.transport;
            rd_word[cfg_menu_pkg::STAT_ACCESS] = access;
            rd_word[cfg_menu_pkg::STAT_LIMIT] = limit_hit;
            rd_word[cfg_menu_pkg::STAT_IN_MENU] = (s_r.st != cfg_menu_pkg::ST_USER
               && s_r.st != cfg_menu_pkg::ST_LOOP_SEL);
            rd_word[cfg_menu_pkg::STAT_EDITING] =
               (s_r.st == cfg_menu_pkg::ST_EDIT);
            rd_word[cfg_menu_pkg::STAT_COUNT_LSB +: 6] = s_r.count;
         end
         cfg_menu_pkg::OFS_DISPLAY:
            rd_word = {16'h0000, s_r.sel_loop, s_r.digit, s_r.item, 3'h0,
                       s_r.st};
         cfg_menu_pkg::OFS_PARAM_SEL: rd_word = {27'h0, s_r.param_sel};
         cfg_menu_pkg::OFS_PARAM_DATA: begin
            if (s_r.param_sel <= cfg_menu_pkg::LAST_ITEM) begin
               rd_word = s_r.vals[s_r.param_sel];
            end else begin
               rd_ok = 1'b0;
            end
         end
         default: rd_ok = 1'b0;
      endcase
      if (s_axi_arvalid && !s_r.rvalid) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = rd_word;
         s_nxt.rresp = rd_ok ? cfg_menu_pkg::RESP_OKAY :
                               cfg_menu_pkg::RESP_SLVERR;
      end else if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.st <= cfg_menu_pkg::ST_USER;
         s_r.transport <= 1'b1;
         s_r.meter_type <= cfg_menu_pkg::RST_METER_TYPE;
         s_r.disable_mask <= cfg_menu_pkg::RST_DISABLE;
         s_r.nominal_flow_rate <= cfg_menu_pkg::RST_NOMINAL;
      end else begin
         s_r <= s_nxt;
      end
   end

   // handshakes
   assign s_axi_awready = ~s_r.aw_got & ~s_r.bvalid;
   assign s_axi_wready  = ~s_r.w_got & ~s_r.bvalid;
   assign s_axi_bvalid  = s_r.bvalid;
   assign s_axi_bresp   = s_r.bresp;
   assign s_axi_arready = ~s_r.rvalid;
   assign s_axi_rvalid  = s_r.rvalid;
   assign s_axi_rdata   = s_r.rdata;
   assign s_axi_rresp   = s_r.rresp;

   // display: item index shown one-based
   always_comb begin
      disp_loop = (s_r.st == cfg_menu_pkg::ST_USER) ? cfg_menu_pkg::LOOP_USER :
                  (s_r.st == cfg_menu_pkg::ST_LOOP_SEL) ? s_r.sel_loop :
                  cfg_menu_pkg::LOOP_SETUP;
      disp_index = s_r.item + 5'h01;
      disp_value = (s_r.st == cfg_menu_pkg::ST_EDIT) ? s_r.edit_val :
                   s_r.vals[s_r.item];
      // no stale cursor outside editing
      disp_digit = (s_r.st == cfg_menu_pkg::ST_EDIT) ? s_r.digit : 3'h0;
      disp_flash = (s_r.st == cfg_menu_pkg::ST_EDIT);
      disp_ok = (s_r.st == cfg_menu_pkg::ST_SAVE_OK) ||
                (s_r.st == cfg_menu_pkg::ST_LOCK_OK);
      disp_off = (s_r.st == cfg_menu_pkg::ST_MENU) && item_off;
      disp_frames = (s_r.st == cfg_menu_pkg::ST_MENU) && s_r.frames_lit;
      disp_frame_level = 3'h0;
      // lock hold grows frames
      if (s_r.st == cfg_menu_pkg::ST_MENU && key_primary &&
          s_r.item == cfg_menu_pkg::ITEM_LOCK) begin
         for (int i = 1; i <= 7; i++) begin
            if (s_r.hold_cnt >= 36'((HOLD_CYC * i) / 8)) begin
               disp_frame_level = 3'(i);
            end
         end
      end
      transport_state = s_r.transport;
      menu_access = access;
   end

endmodule

/* config_menu_access_control_tb.sv */
// self-checking bench: axi4-lite master, key model, status model
// assumes hold 40, save 10, idle 200 cycles
`timescale 1ns/1ps
module config_menu_access_control_tb;
   logic aclk = 1'h0, aresetn = 1'h0, housing_open = 1'h0, ext_we = 1'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, ext_data = 32'h0, s_axi_rdata, disp_value;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [4:0] ext_item = 5'h00, disp_index;
   logic [15:0] flow_rate = 16'h0000;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, key_primary, key_left, key_right, disp_flash, disp_ok;
   logic disp_off, disp_frames, transport_state, menu_access;
   logic [1:0] s_axi_bresp, s_axi_rresp, disp_loop;
   logic [2:0] disp_digit, disp_frame_level;
   int n_mismatch = 0, total_checks = 0, cnt = 0, tr = 1, arm = 0;
   config_menu_access_control #(.HOLD_CYC(36'h28), .SAVE_CYC(36'hA),
      .IDLE_CYC(36'hC8)) dut_u (.*);
   tech_keys tk (.*);
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] st();
      int acc = (cnt < 50 && (tr != 0 || arm != 0)) ? 1 : 0;
      return (32'(cnt) << 8) | (32'(cnt >= 50) << 2) | (32'(acc) << 1) | 32'(tr);
   endfunction
   task automatic rs;
      rd(cfg_menu_pkg::OFS_STATUS, st());
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'h1;
      s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1;
      do @(negedge aclk); while (!(s_axi_awready && s_axi_wready));
      @(posedge aclk);
      s_axi_awvalid <= 1'h0; s_axi_wvalid <= 1'h0;
      do @(negedge aclk); while (s_axi_bvalid !== 1'h1);
      chk(32'(s_axi_bresp), 32'h0);
      @(posedge aclk);
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
      do @(negedge aclk); while (s_axi_arready !== 1'h1);
      @(posedge aclk);
      s_axi_arvalid <= 1'h0;
      do @(negedge aclk); while (s_axi_rvalid !== 1'h1);
      chk(s_axi_rdata, e);
      chk(32'(s_axi_rresp), a > 8'h1C ? 32'h2 : 32'h0);
      @(posedge aclk);
      s_axi_rready <= 1'h0;
   endtask
   // one key session: save and idle out, or lock and release
   task automatic sess(input bit lock);
      int acc = st() >> 1 & 1;
      tk.press(0, 45, 5);
      repeat (3) tk.press(2, 2, 2);
      tk.press(0, 2, 2);
      if (lock) begin
         tk.press(1, 2, 2);
         tk.press(0, 45, 0);
      end else begin
         tk.press(0, 2, 2);
         chk(32'(disp_flash), 32'(acc));
         chk(32'(disp_digit), acc ? 32'h7 : 32'h0);
         tk.press(0, 2, 2);
         tk.press(0, 15, 0);
      end
      #1 chk(32'(disp_ok), 32'(acc));
      repeat (230) @(posedge aclk);
      chk(32'(disp_loop), acc ? 32'h0 : 32'h3);
      if (acc != 0) begin
         if (lock) tr = 0;
         else cnt++;
         if (tr == 0) arm = 0;
      end
   endtask
   initial forever #20 aclk = ~aclk;
   initial begin
      repeat (60000) @(posedge aclk);
      n_mismatch++;
      complete_run;
   end
   initial begin
      void'($urandom(32'h1EA8));
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      rs;
      rd(cfg_menu_pkg::OFS_CONFIG, 32'h1);
      rd(8'h20, 32'h0);
      sess(0);
      wr(cfg_menu_pkg::OFS_PARAM_SEL, 32'h0);
      rd(cfg_menu_pkg::OFS_PARAM_DATA, 32'h10000000);
      rs;
      repeat (49) sess(0);
      sess(0);
      rs;
      wr(cfg_menu_pkg::OFS_CONTROL, 32'h1);
      cnt = 0;
      rs;
      ext_item <= cfg_menu_pkg::ITEM_TIME; ext_data <= $urandom; ext_we <= 1'h1;
      @(posedge aclk) ext_we <= 1'h0;
      wr(cfg_menu_pkg::OFS_PARAM_SEL, 32'(cfg_menu_pkg::ITEM_TIME));
      rd(cfg_menu_pkg::OFS_PARAM_DATA, ext_data);
      wr(cfg_menu_pkg::OFS_NOMINAL, 32'hEA60);
      repeat (20) @(posedge aclk) flow_rate <= 16'($urandom_range(0, 599));
      rs;
      @(posedge aclk) flow_rate <= 16'h0258;
      tr = 0;
      rs;
      @(posedge aclk) housing_open <= 1'h1;
      repeat (3) @(posedge aclk) housing_open <= 1'h0;
      arm = 1;
      rs;
      sess(0);
      rs;
      @(posedge aclk) flow_rate <= 16'h0000;
      wr(cfg_menu_pkg::OFS_CONTROL, 32'h1);
      {cnt, tr} = {32'h0, 32'h1};
      rs;
      sess(1);
      rs;
      complete_run;
   end
endmodule
bind config_menu_access_control cfg_menu_asserts chk_u (.*);

/* tech_keys.sv */
// technician model: presses one front key n cycles
// assumes calls are made right after a rising aclk edge
`timescale 1ns/1ps
module tech_keys (
   input  wire logic aclk,
   output logic      key_primary,
   output logic      key_left,
   output logic      key_right
);
   initial {key_primary, key_left, key_right} = 3'h0;
   task automatic press(input int k, input int n, input int g);
      @(posedge aclk);
      if (k == 0) key_primary <= 1'h1;
      else if (k == 1) key_left <= 1'h1;
      else key_right <= 1'h1;
      repeat (n) @(posedge aclk);
      {key_primary, key_left, key_right} <= 3'h0;
      repeat (g) @(posedge aclk);
   endtask
endmodule
